// *** hw/lps_regs.svh ***
// Functional notes
// - Slave answers at 7-bit address 0111000; pointer byte pattern 010XXXXX then stop.
// - Write burst: pointer byte, then data bytes stored at incrementing addresses, all acked.
// - Read without pointer phase starts at current pointer; host nacks last byte.
// - Sequential read pointer runs 40h to 54h, then wraps to 40h, until stop.
// - Light timing code 1100 (50 ms) halves full scale of both light channels.
// - Normal mode measures proximity once per period; twice mode measures twice.
// - Any write to 41h aborts and restarts the measurement sequence.
// - Power-on reset returns every register to its default value.
// - Device need not respond until 2 ms after power-up.
// - Interrupt pin is open-drain pull-low, released at power-up.
// - Power-down keeps the interrupt pin state; host releases it first.
// - Interrupt released by interrupt reset, read of 4Ah, or software reset.
// - Persistence in 43h applies to proximity interrupts only.
// - Mode 00 unlatched: active above high threshold, inactive below it.
// - Latched output stays active until interrupt reset or read of 4Ah.
// - Persistence needs that many consecutive qualifying results to activate or deactivate.
// - Mode 01: activate above high threshold, deactivate below low threshold.
// - Mode 10: active outside the low-high window, inactive inside it.
// - Light interrupt checks visible channel against its window, latched or not.
// - Trigger field: 00 off, 01 proximity, 10 light, 11 both.
// - Latch bit clear holds output until 4Ah read; set re-evaluates each result.
// - Re-assert bit set briefly releases the pin for each new active result.
`ifndef LPS_REGS_SVH
`define LPS_REGS_SVH

`define LPS_SLAVE_ADDR 7'h38
`define LPS_PTR_PATTERN 3'h2
`define LPS_REG_BASE 8'h40
`define LPS_REG_LAST 8'h54
`define LPS_IDX(a) (5'((a) - `LPS_REG_BASE))

`define LPS_OFS_SYS 8'h40
`define LPS_OFS_MODE 8'h41
`define LPS_OFS_GAIN 8'h42
`define LPS_OFS_PERS 8'h43
`define LPS_OFS_PS_LSB 8'h44
`define LPS_OFS_PS_MSB 8'h45
`define LPS_OFS_VIS_LSB 8'h46
`define LPS_OFS_VIS_MSB 8'h47
`define LPS_OFS_IR_LSB 8'h48
`define LPS_OFS_IR_MSB 8'h49
`define LPS_OFS_INT 8'h4A
`define LPS_OFS_PTH_LSB 8'h4B
`define LPS_OFS_PTH_MSB 8'h4C
`define LPS_OFS_PTL_LSB 8'h4D
`define LPS_OFS_PTL_MSB 8'h4E
`define LPS_OFS_ATH_LSB 8'h4F
`define LPS_OFS_ATH_MSB 8'h50
`define LPS_OFS_ATL_LSB 8'h51
`define LPS_OFS_ATL_MSB 8'h52
`define LPS_OFS_OFF_LSB 8'h53
`define LPS_OFS_OFF_MSB 8'h54

`define LPS_SYS_SWRST_BIT 7
`define LPS_SYS_INTRST_BIT 6
`define LPS_SYS_WMASK 8'h3F
`define LPS_MODE_ALS_EN_BIT 7
`define LPS_MODE_PS_EN_BIT 6
`define LPS_MODE_TWICE_BIT 5
`define LPS_MODE_50MS 4'hC
`define LPS_INT_REASSERT_BIT 3
`define LPS_INT_UNLATCH_BIT 2
`define LPS_MSB12_WMASK 8'h0F
`define LPS_OFF_MSB_WMASK 8'h03

`define LPS_DFLT_FF 8'hFF
`define LPS_DFLT_0F 8'h0F

`define LPS_CLK_HZ 20000000
`define LPS_POR_WAIT_US 2000
`define LPS_POR_WAIT_CYC (`LPS_POR_WAIT_US * (`LPS_CLK_HZ / 1000000))
`define LPS_MEAS_PERIOD_MS 100
`define LPS_MEAS_PERIOD_CYC (`LPS_MEAS_PERIOD_MS * (`LPS_CLK_HZ / 1000))

`endif

// *** hw/lps_pkg.sv ***
package lps_pkg;

    typedef enum logic [2:0] {IDLE, RX, ACK, TX, TXACK} lps_bus_e;

    typedef struct packed {
        logic [11:0] ps;
        logic ps_valid;
        logic [15:0] vis;
        logic [15:0] ir;
        logic als_valid;
    } lps_fe_s;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_d;
        logic sda_s1;
        logic sda_s2;
        logic sda_d;
        lps_bus_e bus;
        logic [7:0] sh;
        logic [3:0] bitcnt;
        logic addr_phase;
        logic first_data;
        logic rd;
        logic [4:0] ptr;
        logic sda_drive;
        logic [20:0][7:0] regs;
        logic [31:0] por_cnt;
        logic [31:0] per_cnt;
        logic [3:0] ps_cnt;
        logic ps_act;
        logic als_act;
        logic blank;
        logic int_drive;
        logic ps_start;
        logic als_start;
        logic restart;
    } lps_state_s;

endpackage

// *** hw/lps_top.sv ***
`timescale 1ns/1ps
`include "lps_regs.svh"

module lps_top
    import lps_pkg::*;
#(
    parameter int unsigned POR_WAIT_CYC = `LPS_POR_WAIT_CYC,
    parameter int unsigned MEAS_PERIOD_CYC = `LPS_MEAS_PERIOD_CYC
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // I2C pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Interrupt pin
    input wire logic int_in,
    output logic int_out,
    output logic int_oe,
    // Analog front end
    input wire lps_fe_s fe,
    output logic ps_start,
    output logic als_start,
    output logic meas_restart,
    output logic als_half_scale,
    output logic [7:0] mode_ctrl,
    output logic [7:0] gain_setting_reg,
    output logic [9:0] ps_offset
);

    lps_state_s s;
    lps_state_s n;
    logic ready;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic do_load;
    logic wr_en;
    logic clr_int;
    logic sw_rst;
    logic ps_on;
    logic ps_off;
    logic als_out;
    logic act_sel;
    logic [3:0] need;
    logic [7:0] tx_byte;
    logic [11:0] pth;
    logic [11:0] ptl;
    logic [15:0] ath;
    logic [15:0] atl;

    function automatic logic [7:0] reg_dflt(input logic [4:0] i);
        logic [7:0] v;
        v = 8'h00;
        if (i == `LPS_IDX(`LPS_OFS_PTH_LSB) || i == `LPS_IDX(`LPS_OFS_ATH_LSB)
            || i == `LPS_IDX(`LPS_OFS_ATH_MSB))
        begin
            v = `LPS_DFLT_FF;
        end
        if (i == `LPS_IDX(`LPS_OFS_PTH_MSB))
        begin
            v = `LPS_DFLT_0F;
        end
        return v;
    endfunction

    function automatic logic [7:0] wr_mask(input logic [4:0] i);
        logic [7:0] m;
        m = 8'hFF;
        if (i == `LPS_IDX(`LPS_OFS_PTH_MSB) || i == `LPS_IDX(`LPS_OFS_PTL_MSB))
        begin
            m = `LPS_MSB12_WMASK;
        end
        if (i == `LPS_IDX(`LPS_OFS_OFF_MSB))
        begin
            m = `LPS_OFF_MSB_WMASK;
        end
        if (i == `LPS_IDX(`LPS_OFS_SYS))
        begin
            m = `LPS_SYS_WMASK;
        end
        return m;
    endfunction

    function automatic logic [4:0] next_ptr(input logic [4:0] p);
        logic [4:0] q;
        q = p + 5'h01;
        if (p >= `LPS_IDX(`LPS_REG_LAST))
        begin
            q = 5'h00;
        end
        return q;
    endfunction

    always_comb
    begin
        n = s;
        do_load = 1'b0;
        wr_en = 1'b0;
        clr_int = 1'b0;
        sw_rst = 1'b0;
        ps_on = 1'b0;
        ps_off = 1'b0;
        als_out = 1'b0;
        tx_byte = 8'h00;
        n.scl_s1 = scl_in;
        n.scl_s2 = s.scl_s1;
        n.scl_d = s.scl_s2;
        n.sda_s1 = sda_in;
        n.sda_s2 = s.sda_s1;
        n.sda_d = s.sda_s2;
        n.ps_start = 1'b0;
        n.als_start = 1'b0;
        n.restart = 1'b0;
        n.blank = 1'b0;
        ready = (s.por_cnt >= POR_WAIT_CYC);
        if (!ready)
        begin
            n.por_cnt = s.por_cnt + 32'h1;
        end
        scl_rise = s.scl_s2 & ~s.scl_d;
        scl_fall = ~s.scl_s2 & s.scl_d;
        start_c = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
        stop_c = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;
        // Bus slave, silent until power-up wait ends
        if (!ready || stop_c)
        begin
            n.bus = IDLE;
            n.sda_drive = 1'b0;
        end
        else if (start_c)
        begin
            n.bus = RX;
            n.bitcnt = 4'h0;
            n.addr_phase = 1'b1;
            n.sda_drive = 1'b0;
        end
        else if (scl_rise)
        begin
            unique case (s.bus)
                IDLE, ACK, TX:
                begin
                end
                RX:
                begin
                    n.sh = {s.sh[6:0], s.sda_s2};
                    n.bitcnt = s.bitcnt + 4'h1;
                end
                TXACK:
                begin
                    if (s.sda_s2)
                    begin
                        n.bus = IDLE;
                    end
                end
            endcase
        end
        else if (scl_fall)
        begin
            unique case (s.bus)
                IDLE:
                begin
                end
                RX:
                begin
                    if (s.bitcnt == 4'h8)
                    begin
                        n.bus = ACK;
                        n.sda_drive = 1'b1;
                        if (s.addr_phase)
                        begin
                            if (s.sh[7:1] == `LPS_SLAVE_ADDR)
                            begin
                                n.rd = s.sh[0];
                                n.addr_phase = 1'b0;
                                n.first_data = 1'b1;
                            end
                            else
                            begin
                                n.bus = IDLE;
                                n.sda_drive = 1'b0;
                            end
                        end
                        else if (s.first_data)
                        begin
                            n.first_data = 1'b0;
                            if (s.sh[7:5] == `LPS_PTR_PATTERN)
                            begin
                                n.ptr = s.sh[4:0];
                            end
                        end
                        else
                        begin
                            wr_en = 1'b1;
                            n.ptr = next_ptr(s.ptr);
                        end
                    end
                end
                ACK:
                begin
                    if (s.rd)
                    begin
                        do_load = 1'b1;
                    end
                    else
                    begin
                        n.bus = RX;
                        n.bitcnt = 4'h0;
                        n.sda_drive = 1'b0;
                    end
                end
                TX:
                begin
                    if (s.bitcnt == 4'h8)
                    begin
                        n.sda_drive = 1'b0;
                        n.bus = TXACK;
                    end
                    else
                    begin
                        n.sda_drive = ~s.sh[3'(4'h7 - s.bitcnt)];
                        n.bitcnt = s.bitcnt + 4'h1;
                    end
                end
                TXACK:
                begin
                    do_load = 1'b1;
                end
            endcase
        end
        if (do_load)
        begin
            if (s.ptr <= `LPS_IDX(`LPS_REG_LAST))
            begin
                tx_byte = s.regs[s.ptr];
            end
            n.sh = tx_byte;
            n.sda_drive = ~tx_byte[7];
            n.bitcnt = 4'h1;
            n.bus = TX;
            n.ptr = next_ptr(s.ptr);
            clr_int = (s.ptr == `LPS_IDX(`LPS_OFS_INT));
        end
        if (wr_en && s.ptr <= `LPS_IDX(`LPS_REG_LAST))
        begin
            if (s.ptr == `LPS_IDX(`LPS_OFS_SYS))
            begin
                sw_rst = s.sh[`LPS_SYS_SWRST_BIT];
                clr_int = s.sh[`LPS_SYS_INTRST_BIT];
            end
            if (s.ptr < `LPS_IDX(`LPS_OFS_PS_LSB) || s.ptr > `LPS_IDX(`LPS_OFS_IR_MSB))
            begin
                n.regs[s.ptr] = s.sh & wr_mask(s.ptr);
            end
            n.restart = (s.ptr == `LPS_IDX(`LPS_OFS_MODE));
        end
        // Measurement sequencer
        if (n.restart || s.per_cnt >= MEAS_PERIOD_CYC - 1)
        begin
            n.per_cnt = 32'h0;
            // Use the value being written so a restart never starts with stale enables
            n.ps_start = n.regs[1][`LPS_MODE_PS_EN_BIT];
            n.als_start = n.regs[1][`LPS_MODE_ALS_EN_BIT];
        end
        else
        begin
            n.per_cnt = s.per_cnt + 32'h1;
            if (s.regs[1][`LPS_MODE_TWICE_BIT] && s.per_cnt == MEAS_PERIOD_CYC / 2 - 1)
            begin
                n.ps_start = s.regs[1][`LPS_MODE_PS_EN_BIT];
            end
        end
        if (fe.ps_valid)
        begin
            n.regs[4] = fe.ps[7:0];
            n.regs[5] = {4'h0, fe.ps[11:8]};
        end
        if (fe.als_valid)
        begin
            n.regs[6] = fe.vis[7:0];
            n.regs[7] = fe.vis[15:8];
            n.regs[8] = fe.ir[7:0];
            n.regs[9] = fe.ir[15:8];
        end
        // Interrupt evaluation; a clear and a new result in one cycle keep the result
        if (clr_int || sw_rst)
        begin
            n.ps_act = 1'b0;
            n.als_act = 1'b0;
            n.ps_cnt = 4'h0;
        end
        pth = {s.regs[12][3:0], s.regs[11]};
        ptl = {s.regs[14][3:0], s.regs[13]};
        ath = {s.regs[16], s.regs[15]};
        atl = {s.regs[18], s.regs[17]};
        need = (s.regs[3][3:0] == 4'h0) ? 4'h1 : s.regs[3][3:0];
        unique case (s.regs[10][5:4])
            2'h1:
            begin
                ps_on = fe.ps > pth;
                ps_off = fe.ps < ptl;
            end
            2'h2:
            begin
                ps_on = fe.ps > pth || fe.ps < ptl;
                ps_off = !ps_on;
            end
            2'h0, 2'h3:
            begin
                ps_on = fe.ps > pth;
                ps_off = fe.ps < pth;
            end
        endcase
        if (fe.ps_valid)
        begin
            if (!n.ps_act)
            begin
                if (ps_on && n.ps_cnt + 4'h1 >= need)
                begin
                    n.ps_act = 1'b1;
                    n.ps_cnt = 4'h0;
                end
                else
                begin
                    n.ps_cnt = ps_on ? n.ps_cnt + 4'h1 : 4'h0;
                end
            end
            else if (s.regs[10][`LPS_INT_UNLATCH_BIT])
            begin
                if (ps_off && n.ps_cnt + 4'h1 >= need)
                begin
                    n.ps_act = 1'b0;
                    n.ps_cnt = 4'h0;
                end
                else
                begin
                    n.ps_cnt = ps_off ? n.ps_cnt + 4'h1 : 4'h0;
                end
            end
        end
        als_out = fe.vis > ath || fe.vis < atl;
        if (fe.als_valid)
        begin
            if (s.regs[10][`LPS_INT_UNLATCH_BIT])
            begin
                n.als_act = als_out;
            end
            else if (als_out)
            begin
                n.als_act = 1'b1;
            end
        end
        act_sel = (s.regs[10][0] & n.ps_act) | (s.regs[10][1] & n.als_act);
        if (s.regs[10][`LPS_INT_REASSERT_BIT] && s.int_drive && act_sel
            && ((s.regs[10][0] & fe.ps_valid) | (s.regs[10][1] & fe.als_valid)))
        begin
            n.blank = 1'b1;
        end
        n.int_drive = act_sel & ~n.blank;
        if (sw_rst)
        begin
            for (int i = 0; i <= 20; i++)
            begin
                n.regs[i] = reg_dflt(5'(i));
            end
        end
        if (rst)
        begin
            n = '0;
            for (int i = 0; i <= 20; i++)
            begin
                n.regs[i] = reg_dflt(5'(i));
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        s <= n;
    end

    assign sda_out = 1'b0;
    assign sda_oe = s.sda_drive;
    assign int_out = 1'b0;
    assign int_oe = s.int_drive;
    assign ps_start = s.ps_start;
    assign als_start = s.als_start;
    assign meas_restart = s.restart;
    assign als_half_scale = (s.regs[1][3:0] == `LPS_MODE_50MS);
    assign mode_ctrl = s.regs[1];
    assign gain_setting_reg = s.regs[2];
    assign ps_offset = {s.regs[20][1:0], s.regs[19]};

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_int_released_reset: assert property ($fell(rst) |-> !int_oe)
        else $error("interrupt pin driven after reset");
    a_quiet_before_ready: assert property (!ready |-> ##1 !sda_oe)
        else $error("bus driven during power-up wait");
    a_addr_ack_match: assert property (s.bus == RX && scl_fall && !start_c && !stop_c
        && s.bitcnt == 4'h8 && s.addr_phase && s.sh[7:1] == `LPS_SLAVE_ADDR
        |=> sda_oe ##1 sda_oe)
        else $error("own address not acknowledged");
    a_addr_nack_other: assert property (s.bus == RX && scl_fall && !stop_c
        && s.bitcnt == 4'h8 && s.addr_phase && s.sh[7:1] != `LPS_SLAVE_ADDR
        |=> !sda_oe && s.bus == IDLE)
        else $error("foreign address acknowledged");
    a_ptr_wrap_last: assert property (do_load && s.ptr == `LPS_IDX(`LPS_REG_LAST)
        |=> s.ptr == 5'h00)
        else $error("pointer did not wrap to 40h");
    a_mode_write_restart: assert property (wr_en && s.ptr == `LPS_IDX(`LPS_OFS_MODE)
        |=> meas_restart && s.per_cnt == 32'h0)
        else $error("mode write did not restart");
    a_int_read_release: assert property (do_load && s.ptr == `LPS_IDX(`LPS_OFS_INT)
        && !fe.ps_valid && !fe.als_valid |=> !int_oe)
        else $error("read of 4Ah did not release interrupt");
    a_ps_level_mode: assert property (fe.ps_valid && s.regs[10][5:0] == 6'h05
        && s.regs[3][3:0] == 4'h0 && fe.ps > pth && !clr_int && !sw_rst
        |=> int_oe)
        else $error("proximity above high threshold not flagged");
    a_latch_hold: assert property (int_oe && !s.regs[10][`LPS_INT_UNLATCH_BIT]
        && !s.regs[10][`LPS_INT_REASSERT_BIT] && !clr_int && !sw_rst
        && s.regs[10][1:0] != 2'h0 |=> int_oe)
        else $error("latched interrupt dropped");
    a_als_no_consecutive_count_reg: assert property (fe.als_valid && s.regs[10][5:0] == 6'h06
        && s.regs[3][3:0] == 4'hF && als_out && !clr_int && !sw_rst |=> int_oe)
        else $error("light interrupt delayed by persistence");

    c_read_burst: cover property (do_load ##[1:400] do_load);
    c_ptr_wrap: cover property (do_load && s.ptr == `LPS_IDX(`LPS_REG_LAST));
    c_int_reassert: cover property (s.blank);
    c_ps_consecutive_count_reg: cover property (fe.ps_valid && s.ps_cnt != 4'h0);

endmodule

// *** test/lps_host.sv ***
`timescale 1ns/1ps

module lps_host
(
    // Bus pins, released level is high
    output logic scl,
    output logic sda_drv,
    input wire logic sda
);
    localparam int HALF = 200;

    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic bit_io(input logic b, output logic r);
        #(HALF / 2) sda_drv = b;
        #(HALF / 2) scl = 1'b1;
        #(HALF / 2) r = sda;
        #(HALF / 2) scl = 1'b0;
    endtask

    task automatic start();
        #(HALF / 2) sda_drv = 1'b1;
        #(HALF / 2) scl = 1'b1;
        #HALF sda_drv = 1'b0;
        #HALF scl = 1'b0;
    endtask

    task automatic stop();
        #(HALF / 2) sda_drv = 1'b0;
        #(HALF / 2) scl = 1'b1;
        #HALF sda_drv = 1'b1;
        #HALF;
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask

    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(!more, r);
    endtask

    task automatic xfer_wr(input logic [7:0] q[$], output logic ok);
        logic a;
        ok = 1'b1;
        start();
        foreach (q[i])
        begin
            wbyte(q[i], a);
            ok &= a;
        end
        stop();
    endtask

    task automatic xfer_rd(input logic [7:0] ptr, input int n, input logic sr,
        output logic [7:0] q[$]);
        logic a;
        logic [7:0] d;
        q = {};
        start();
        wbyte(8'h70, a);
        wbyte(ptr, a);
        if (!sr)
            stop();
        start();
        wbyte(8'h71, a);
        for (int i = 0; i < n; i++)
        begin
            rbyte(i < n - 1, d);
            q.push_back(d);
        end
        stop();
    endtask
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps

module testbench
    import lps_pkg::*;
;
    localparam int unsigned POR_CYC = 20;
    localparam int unsigned PER_CYC = 200;
    logic clk_sys, rst, scl, sda_drv, sda, sda_out, sda_oe, int_oe, ok;
    logic ps_start, als_start, meas_restart, als_half_scale;
    logic [7:0] mode_ctrl, gain_setting_reg;
    logic [9:0] ps_offset;
    logic [7:0] q[$];
    lps_fe_s fe;
    int miscompares = 0;
    int samples_checked = 0;
    int restarts = 0;
    int ps_starts = 0;
    int als_starts = 0;

    // Open-drain wire with pull-up: the device pulls to its driven level
    assign sda = sda_drv & (sda_oe ? sda_out : 1'b1);

    lps_top #(.POR_WAIT_CYC(POR_CYC), .MEAS_PERIOD_CYC(PER_CYC)) i_lps_top (
        .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .int_in(!int_oe), .int_out(), .int_oe(int_oe), .fe(fe),
        .ps_start(ps_start), .als_start(als_start), .meas_restart(meas_restart),
        .als_half_scale(als_half_scale), .mode_ctrl(mode_ctrl),
        .gain_setting_reg(gain_setting_reg), .ps_offset(ps_offset));
    lps_host i_lps_host (.scl(scl), .sda_drv(sda_drv), .sda(sda));

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        if (meas_restart === 1'b1)
            restarts <= restarts + 1;
        if (ps_start === 1'b1)
            ps_starts <= ps_starts + 1;
        if (als_start === 1'b1)
            als_starts <= als_starts + 1;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] w[$]);
        i_lps_host.xfer_wr({8'h70, w}, ok);
        chk(ok, 1'b1);
    endtask

    task automatic rd(input logic [7:0] ptr, input logic [7:0] e[$], input logic sr);
        i_lps_host.xfer_rd(ptr, e.size(), sr, q);
        foreach (e[i])
            chk(q[i], e[i]);
    endtask

    task automatic meas(input logic is_ps, input logic [15:0] v, input logic e);
        @(negedge clk_sys);
        fe.ps = v[11:0];
        fe.vis = v;
        fe.ps_valid = is_ps;
        fe.als_valid = !is_ps;
        @(negedge clk_sys);
        fe.ps_valid = 1'b0;
        fe.als_valid = 1'b0;
        @(negedge clk_sys);
        chk(int_oe, e);
    endtask

    task automatic cfg(input logic [7:0] c, input logic [7:0] p);
        wr({8'h43, p, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, c, 8'h00, 8'h02, 8'h00,
            8'h01, 8'h00, 8'h20, 8'h00, 8'h10});
        wr({8'h40, 8'h40});
        @(negedge clk_sys);
        chk(int_oe, 1'b0);
    endtask

    task automatic t_reset();
        chk(int_oe, 1'b0);
        chk(sda_oe, 1'b0);
        rd(8'h4B, {8'hFF, 8'h0F, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00},
            1'b0);
        i_lps_host.start();
        i_lps_host.wbyte(8'h72, ok);
        i_lps_host.stop();
        chk(ok, 1'b0);
    endtask

    task automatic t_wrap();
        wr({8'h53, 8'hAB, 8'h03, 8'h00});
        chk(ps_offset, 10'h3AB);
        rd(8'h53, {8'hAB, 8'h03, 8'h00, 8'h00}, 1'b1);
    endtask

    task automatic t_seq();
        int r0, p0, a0;
        r0 = restarts;
        wr({8'h41, 8'h8C, 8'h5A});
        chk(restarts - r0, 1);
        chk(gain_setting_reg, 8'h5A);
        chk(mode_ctrl, 8'h8C);
        chk(als_half_scale, 1'b1);
        // Overflowed light result in 50 ms mode, fixed up by host software
        meas(0, 16'h8123, 1'b0);
        rd(8'h46, {8'h23, 8'h81}, 1'b1);
        chk(q[1][7] ? 16'h7FFF : {q[1], q[0]}, 16'h7FFF);
        for (int m = 0; m < 2; m++)
        begin
            wr({8'h41, m ? 8'h60 : 8'hC0});
            chk(als_half_scale, 1'b0);
            repeat (10) @(negedge clk_sys);
            p0 = ps_starts;
            a0 = als_starts;
            repeat (PER_CYC) @(negedge clk_sys);
            chk(ps_starts - p0, m + 1);
            chk(als_starts - a0, 1 - m);
        end
        wr({8'h41, 8'h00});
    endtask

    task automatic t_int();
        cfg(8'h05, 8'h00);
        meas(1, 16'h201, 1);
        meas(1, 16'h1FF, 0);
        cfg(8'h15, 8'h00);
        meas(1, 16'h201, 1);
        meas(1, 16'h180, 1);
        meas(1, 16'h0FF, 0);
        cfg(8'h25, 8'h00);
        meas(1, 16'h180, 0);
        meas(1, 16'h201, 1);
        meas(1, 16'h0FF, 1);
        meas(1, 16'h150, 0);
        cfg(8'h01, 8'h00);
        meas(1, 16'h201, 1);
        meas(1, 16'h000, 1);
        rd(8'h4A, {8'h01}, 1'b1);
        chk(int_oe, 1'b0);
        meas(1, 16'h201, 1);
        wr({8'h40, 8'h80});
        chk(int_oe, 1'b0);
        rd(8'h4A, {8'h00, 8'hFF}, 1'b1);
        cfg(8'h04, 8'h00);
        meas(1, 16'h201, 0);
        cfg(8'h06, 8'h00);
        meas(1, 16'h201, 0);
        meas(0, 16'h3000, 1);
        meas(0, 16'h1800, 0);
        meas(0, 16'h0800, 1);
        wr({8'h41, 8'h00});
        chk(int_oe, 1'b1);
        cfg(8'h07, 8'h00);
        meas(1, 16'h201, 1);
        // Re-assert: a second active result releases the pin for one cycle
        cfg(8'h0D, 8'h00);
        meas(1, 16'h201, 1);
        @(negedge clk_sys);
        fe.ps_valid = 1'b1;
        @(negedge clk_sys);
        fe.ps_valid = 1'b0;
        chk(int_oe, 1'b0);
        @(negedge clk_sys);
        chk(int_oe, 1'b1);
        cfg(8'h05, 8'h03);
        meas(1, 16'h201, 0);
        meas(1, 16'h201, 0);
        meas(1, 16'h201, 1);
        meas(1, 16'h1FF, 1);
        meas(1, 16'h1FF, 1);
        meas(1, 16'h1FF, 0);
        cfg(8'h06, 8'h0F);
        meas(0, 16'h3000, 1);
    endtask

    initial
    begin
        rst = 1'b1;
        fe = '0;
        fe.ir = 16'hFFFF;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        repeat (POR_CYC + 3) @(negedge clk_sys);
        t_reset();
        t_wrap();
        t_seq();
        t_int();
        results();
    end

    initial
    begin
        #4_500_000;
        miscompares++;
        results();
    end
endmodule
